// ===== pil_pkg.sv
// Constants for the interrupt and link-policy block of the transceiver.
// Assumes a 5-bit management register address and 16-bit register data.
package pil_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
	localparam logic [4:0] ADDR_INT_ENABLE_CONFIG = 5'h11;
	localparam logic [4:0] ADDR_INT_STATUS = 5'h12;
	localparam logic [4:0] ADDR_PORT_CONFIG = 5'h13;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TEST_INT_FORCE_BIT = 0;
	localparam int INT_GLOBAL_ENABLE_BIT = 1;
	localparam int LINK_LOSS_POLICY_BIT = 2;
	localparam int DRIVE_LEVEL_BIT = 3;
	localparam int PENDING_FLAG_BIT = 15;
	localparam int CLOCKS_STABLE_BIT = 14;
	localparam int MDIO_INT_ENABLE_BIT = 12;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic RST_TEST_INT_FORCE = 1'b0;
	localparam logic RST_INT_GLOBAL_ENABLE = 1'b0;
	localparam logic RST_LINK_LOSS_POLICY = 1'b0;
	localparam logic RST_DRIVE_LEVEL = 1'b0;
	localparam logic RST_MDIO_INT_ENABLE = 1'b0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	// Least time without scrambler lock before the link drops
	localparam int LOCK_LOSS_MIN_NS = 1000000;
	localparam int LOCK_LOSS_CYCLES =
		(LOCK_LOSS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {PIL_LINK_DOWN, PIL_LINK_UP} pil_link_e;
endpackage

// ===== pil_interrupt_link_policy.sv
// Interrupt control and 100 Mbit link-loss policy of the transceiver.
// Assumes the serial management engine presents decoded register reads
// and writes as one-cycle strobes on core_clk; link inputs are synchronous.
`timescale 1ns/100ps

// Summary of operation
// - A zero global interrupt enable disables all interrupts, including the test force and management-line signalling.
// - Writing one to the test interrupt bit pulls the interrupt output low and sets the pending flag.
// - A test interrupt also sends an interrupt pulse on the management line when that signalling is enabled.
// - The test bit has no effect unless the global enable is set, and at zero normal operation applies.
// - With the enhanced policy the link drops after scrambler lock is lost for at least one millisecond.
// - Under the enhanced policy link-up still follows the symbol error rate.
// - Under the standard policy, the reset default, link-up and link-loss follow the symbol error rate only.
// - The pending flag holds until basic status is read and then the interrupt status is read.
// - The management-line interrupt enable allows that signalling only together with the global enable.
module pil_interrupt_link_policy #(
	parameter int LOSS_CYCLES = pil_pkg::LOCK_LOSS_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register access from the management engine
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_hit,
	// Interrupt sources and outputs
	input wire logic int_event,
	input wire logic clocks_stable,
	output logic interrupt_out_n,
	output logic mdio_int_pulse,
	// Link policy
	input wire logic scrambler_locked,
	input wire logic ser_link_ok,
	output logic link_up,
	output logic media_if_drive_level_select
);
	// ****************************************
	// Register storage
	// ****************************************
	logic test_interrupt_force_reg;
	logic interrupt_global_enable_reg;
	logic link_loss_policy_select_reg;
	logic drive_level_reg;
	logic mdio_int_enable_reg;
	logic interrupt_pending_flag_reg;
	logic status_seen_reg;
	logic test_interrupt_force_prev_reg;
	logic irq_n_reg;
	logic pulse_reg;
	logic [15:0] rdata_reg;
	logic hit_reg;
	logic [31:0] loss_cnt_reg;
	logic [31:0] loss_cnt_next;
	pil_pkg::pil_link_e link_reg;
	pil_pkg::pil_link_e link_next;

	// ****************************************
	// Decode
	// ****************************************
	wire wr_cfg = reg_wr_en && reg_addr == pil_pkg::ADDR_INT_ENABLE_CONFIG;
	wire wr_port = reg_wr_en && reg_addr == pil_pkg::ADDR_PORT_CONFIG;
	wire rd_basic = reg_rd_en && reg_addr == pil_pkg::ADDR_BASIC_STATUS;
	wire rd_status = reg_rd_en && reg_addr == pil_pkg::ADDR_INT_STATUS;
	wire addr_ours = reg_addr == pil_pkg::ADDR_INT_ENABLE_CONFIG ||
		reg_addr == pil_pkg::ADDR_INT_STATUS ||
		reg_addr == pil_pkg::ADDR_PORT_CONFIG;

	// Reserved bits are dropped on write and read back as zero
	wire [15:0] cfg_word = 16'h0000 |
		(16'(test_interrupt_force_reg) << pil_pkg::TEST_INT_FORCE_BIT) |
		(16'(interrupt_global_enable_reg) << pil_pkg::INT_GLOBAL_ENABLE_BIT) |
		(16'(link_loss_policy_select_reg) << pil_pkg::LINK_LOSS_POLICY_BIT) |
		(16'(drive_level_reg) << pil_pkg::DRIVE_LEVEL_BIT);
	wire [15:0] status_word =
		(16'(interrupt_pending_flag_reg) << pil_pkg::PENDING_FLAG_BIT) |
		(16'(clocks_stable) << pil_pkg::CLOCKS_STABLE_BIT);
	wire [15:0] port_word =
		16'(mdio_int_enable_reg) << pil_pkg::MDIO_INT_ENABLE_BIT;
	wire [15:0] rd_word = reg_addr == pil_pkg::ADDR_INT_ENABLE_CONFIG ?
		cfg_word : reg_addr == pil_pkg::ADDR_INT_STATUS ? status_word :
		reg_addr == pil_pkg::ADDR_PORT_CONFIG ? port_word : 16'h0000;

	// ****************************************
	// Interrupt logic
	// ****************************************
	// Test force only counts while interrupts are globally enabled
	wire test_interrupt_force_active = interrupt_global_enable_reg &&
		test_interrupt_force_reg;
	wire pend_set = interrupt_global_enable_reg &&
		(test_interrupt_force_reg || int_event);
	// Basic status read followed by status read clears; a new set still wins
	wire pend_clr = rd_status && status_seen_reg;
	wire pend_next = pend_set || (interrupt_pending_flag_reg && !pend_clr);
	wire irq_n_next = !(interrupt_global_enable_reg &&
		(interrupt_pending_flag_reg || test_interrupt_force_reg));
	// Edge of the effective force, so enabling with the bit set still pulses
	wire pulse_next = interrupt_global_enable_reg && mdio_int_enable_reg &&
		(int_event || (test_interrupt_force_active && !test_interrupt_force_prev_reg));

	// ****************************************
	// Link policy
	// ****************************************
	wire enhanced = link_loss_policy_select_reg;
	wire loss_expired = loss_cnt_reg == 32'(LOSS_CYCLES - 1) &&
		!scrambler_locked;

	always_comb begin
		loss_cnt_next = 32'h00000000;
		if (link_reg == pil_pkg::PIL_LINK_UP && enhanced && !scrambler_locked &&
			!loss_expired) begin
			loss_cnt_next = loss_cnt_reg + 32'h00000001;
		end
	end

	always_comb begin
		case (link_reg)
			pil_pkg::PIL_LINK_DOWN: begin
				link_next = ser_link_ok ? pil_pkg::PIL_LINK_UP :
					pil_pkg::PIL_LINK_DOWN;
			end
			pil_pkg::PIL_LINK_UP: begin
				if (enhanced) begin
					link_next = loss_expired ? pil_pkg::PIL_LINK_DOWN :
						pil_pkg::PIL_LINK_UP;
				end else begin
					link_next = ser_link_ok ? pil_pkg::PIL_LINK_UP :
						pil_pkg::PIL_LINK_DOWN;
				end
			end
			default: link_next = pil_pkg::PIL_LINK_DOWN;
		endcase
	end

	// ****************************************
	// Flip-flops
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			test_interrupt_force_reg <= pil_pkg::RST_TEST_INT_FORCE;
			interrupt_global_enable_reg <= pil_pkg::RST_INT_GLOBAL_ENABLE;
			link_loss_policy_select_reg <= pil_pkg::RST_LINK_LOSS_POLICY;
			drive_level_reg <= pil_pkg::RST_DRIVE_LEVEL;
		end else if (wr_cfg) begin
			test_interrupt_force_reg <= reg_wdata[pil_pkg::TEST_INT_FORCE_BIT];
			interrupt_global_enable_reg <=
				reg_wdata[pil_pkg::INT_GLOBAL_ENABLE_BIT];
			link_loss_policy_select_reg <=
				reg_wdata[pil_pkg::LINK_LOSS_POLICY_BIT];
			drive_level_reg <= reg_wdata[pil_pkg::DRIVE_LEVEL_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mdio_int_enable_reg <= pil_pkg::RST_MDIO_INT_ENABLE;
		end else if (wr_port) begin
			mdio_int_enable_reg <= reg_wdata[pil_pkg::MDIO_INT_ENABLE_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			interrupt_pending_flag_reg <= 1'b0;
			status_seen_reg <= 1'b0;
			test_interrupt_force_prev_reg <= 1'b0;
			irq_n_reg <= 1'b1;
			pulse_reg <= 1'b0;
		end else begin
			interrupt_pending_flag_reg <= pend_next;
			// Any read other than basic status breaks the clearing sequence
			if (reg_rd_en) begin
				status_seen_reg <= rd_basic;
			end
			test_interrupt_force_prev_reg <= test_interrupt_force_active;
			irq_n_reg <= irq_n_next;
			pulse_reg <= pulse_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_reg <= 16'h0000;
			hit_reg <= 1'b0;
			loss_cnt_reg <= 32'h00000000;
			link_reg <= pil_pkg::PIL_LINK_DOWN;
		end else begin
			if (reg_rd_en) begin
				rdata_reg <= rd_word;
			end
			hit_reg <= reg_rd_en && addr_ours;
			loss_cnt_reg <= loss_cnt_next;
			link_reg <= link_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_hit = hit_reg;
	assign interrupt_out_n = irq_n_reg;
	assign mdio_int_pulse = pulse_reg;
	assign link_up = link_reg == pil_pkg::PIL_LINK_UP;
	assign media_if_drive_level_select = drive_level_reg;

	// ****************************************
	// Checks
	// ****************************************
	a_irq_disabled_high: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!interrupt_global_enable_reg |=> interrupt_out_n)
		else $error("interrupt asserted while globally disabled");
	a_test_forces_low: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		test_interrupt_force_active |=> !interrupt_out_n && interrupt_pending_flag_reg)
		else $error("test force did not assert interrupt and flag");
	a_mdio_pulse_cause: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		mdio_int_pulse |-> $past(interrupt_global_enable_reg &&
		mdio_int_enable_reg))
		else $error("management line pulse without enables");
	a_test_ignored_off: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!interrupt_global_enable_reg && !interrupt_pending_flag_reg
		|=> !interrupt_pending_flag_reg)
		else $error("pending set while interrupts disabled");
	a_enh_lock_loss: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		link_up && enhanced && loss_expired |=> !link_up)
		else $error("enhanced policy kept link after lock loss");
	a_link_up_ser: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!link_up && ser_link_ok |=> link_up)
		else $error("link not raised on good symbol error rate");
	a_std_link_loss: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		link_up && !enhanced && !ser_link_ok |=> !link_up)
		else $error("standard policy kept link on bad error rate");
	a_pending_holds: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		interrupt_pending_flag_reg && !pend_clr |=> interrupt_pending_flag_reg)
		else $error("pending flag lost without clearing sequence");
	a_test_interrupt_force_rise_pulse: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(test_interrupt_force_active) && mdio_int_enable_reg && !test_interrupt_force_prev_reg
		|=> mdio_int_pulse)
		else $error("no management line pulse on test force");
	a_irq_release: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!interrupt_pending_flag_reg && !test_interrupt_force_reg
		|=> interrupt_out_n)
		else $error("interrupt held with nothing pending");
endmodule // pil_interrupt_link_policy

// ===== pil_mgmt_model.sv
// Station management controller model driving the register strobes.
// Assumes the design takes strobes on the rising edge of core_clk.
`timescale 1ns/100ps
module pil_mgmt_model (
	// Clock
	input wire logic core_clk,
	// Register bus
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [4:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = (a == pil_pkg::ADDR_PORT_CONFIG) ? (d & 16'h1000) :
			(d & 16'h000f);
		reg_wr_en = 1'b1;
		@(negedge core_clk);
		reg_wr_en = 1'b0;
		// Idle data toggles so a stale value is never mistaken for a write
		reg_wdata = ~reg_wdata;
	endtask
	// Clearing pending needs a read of 1 followed by a read of 18
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge core_clk);
		reg_rd_en = 1'b0;
		d = reg_rdata;
	endtask
endmodule // pil_mgmt_model

// ===== phy_interrupt_and_link_policy_tb_top.sv
// Self-checking bench for the interrupt and link-policy block.
// Assumes the management model above; loss count shortened to 8.
`timescale 1ns/100ps
module phy_interrupt_and_link_policy_tb_top;
	logic core_clk, rst_n, wr, rde, hit, ev, cs, intn, pul, lk, ser, up, drv;
	logic [4:0] ad;
	logic [15:0] wd, rdat, d;
	logic [31:0] seed;
	int fail_count, checks, pulses, cyc, p0;
	// Set only by the cycle limit; counted as one mismatch in the report
	bit timed_out;
	pil_interrupt_link_policy #(.LOSS_CYCLES(8)) pil_interrupt_link_policy_inst (
		.core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(wr), .reg_rd_en(rde),
		.reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat), .reg_hit(hit),
		.int_event(ev), .clocks_stable(cs), .interrupt_out_n(intn),
		.mdio_int_pulse(pul), .scrambler_locked(lk), .ser_link_ok(ser),
		.link_up(up), .media_if_drive_level_select(drv));
	pil_mgmt_model pil_mgmt_model_inst (.core_clk(core_clk), .reg_wr_en(wr),
		.reg_rd_en(rde), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (pul === 1'b1) pulses++;
		if (cyc == 3000) begin
			timed_out = 1'b1;
			complete_run();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [15:0] st(input logic p);
		return {p, cs, 14'h0000};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic clr();
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_BASIC_STATUS, d);
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_STATUS, d);
	endtask
	task automatic complete_run();
		$display("checks %0d fail_count %0d", checks,
			fail_count + int'(timed_out));
		if (fail_count == 0 && !timed_out && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		ev = 1'b0;
		cs = 1'b1;
		lk = 1'b1;
		ser = 1'b0;
		seed = 32'h8d058383;
		w(8);
		rst_n = 1'b1;
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_ENABLE_CONFIG, d);
		chk("config reset", 16'h0000, d);
		chk("irq reset", 16'h0001, {15'h0, intn});
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, 16'h0001);
		w(4);
		chk("test ignored", 16'h0001, {15'h0, intn});
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_STATUS, d);
		chk("no pending", st(1'b0), d);
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_PORT_CONFIG, 16'h1000);
		p0 = pulses;
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, 16'h0003);
		w(4);
		chk("test irq", 16'h0000, {15'h0, intn});
		chk("line pulse", 16'h0001, 16'(pulses - p0));
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, 16'h0002);
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_STATUS, d);
		chk("pending set", st(1'b1), d);
		w(3);
		chk("pending holds", 16'h0000, {15'h0, intn});
		clr();
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_STATUS, d);
		chk("pending clear", st(1'b0), d);
		chk("irq release", 16'h0001, {15'h0, intn});
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_PORT_CONFIG, 16'h0000);
		p0 = pulses;
		ev = 1'b1;
		w(1);
		ev = 1'b0;
		w(4);
		chk("no line pulse", 16'h0000, 16'(pulses - p0));
		chk("event irq", 16'h0000, {15'h0, intn});
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, 16'h0000);
		w(3);
		chk("disabled irq", 16'h0001, {15'h0, intn});
		clr();
		ev = 1'b1;
		cs = 1'b0;
		w(1);
		ev = 1'b0;
		pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_STATUS, d);
		chk("event masked", st(1'b0), d);
		cs = 1'b1;
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, seed[15:0]);
			pil_mgmt_model_inst.rd(pil_pkg::ADDR_INT_ENABLE_CONFIG, d);
			chk("config", seed[15:0] & 16'h000f, d);
			chk("config hit", 16'h0001, {15'h0, hit});
			chk("drive", {15'h0, seed[3]}, {15'h0, drv});
			pil_mgmt_model_inst.rd({2'b00, seed[18:16]} | 5'h04, d);
			chk("unmapped", 16'h0000, d);
			chk("unmapped hit", 16'h0000, {15'h0, hit});
		end
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, 16'h0000);
		clr();
		ser = 1'b1;
		w(3);
		chk("std up", 16'h0001, {15'h0, up});
		ser = 1'b0;
		w(3);
		chk("std down", 16'h0000, {15'h0, up});
		pil_mgmt_model_inst.wr(pil_pkg::ADDR_INT_ENABLE_CONFIG, 16'h0004);
		ser = 1'b1;
		w(3);
		chk("enh up", 16'h0001, {15'h0, up});
		ser = 1'b0;
		w(3);
		chk("enh ser ignored", 16'h0001, {15'h0, up});
		lk = 1'b0;
		w(4);
		chk("enh short loss", 16'h0001, {15'h0, up});
		// Seven unlocked edges keep the link, the eighth drops it
		w(3);
		chk("enh last up", 16'h0001, {15'h0, up});
		w(1);
		chk("enh down", 16'h0000, {15'h0, up});
		lk = 1'b1;
		complete_run();
	end
endmodule // phy_interrupt_and_link_policy_tb_top
